// >>> logic/fcw_decoder.sv
// Purpose: Decode drive command word, hold bus settings, count bus errors
// Assumes: Framer outside delivers words, settings and error pulses
// Notes: Watchdog counts whole milliseconds from a cycle prescaler
`include "fcw_regs.svh"
`default_nettype none
module fcw_decoder
  import fcw_pkg::*;
#(
  parameter int MS_CYCLES = `FCW_MS_NS / `FCW_CLK_PERIOD_NS
)
(
  input wire logic sys_clk_i,
  input wire logic rst_b_i,
  input wire logic cmd_wr_i,
  input wire logic [15:0] cmd_word_i,
  input wire logic par_wr_i,
  input wire logic [3:0] par_idx_i,
  input wire logic [15:0] par_data_i,
  input wire logic [7:0] err_evt_i,
  input wire logic [2:0] cnt_idx_i,
  input wire logic drive_fault_i,
  input wire logic standstill_i,
  output logic [15:0] cnt_data_o,
  output logic pulse_en_o,
  output logic ramp_stop_o,
  output logic coast_stop_o,
  output logic fast_stop_o,
  output logic rfg_zero_o,
  output logic rfg_hold_o,
  output logic setpoint_en_o,
  output logic dir_rev_o,
  output logic mop_up_o,
  output logic mop_down_o,
  output logic bus_ctrl_o,
  output logic fault_o,
  output logic inhibit_o,
  output logic ready_o,
  output logic op_en_o,
  output logic [15:0] proc_time_o,
  output logic [15:0] char_delay_o,
  output logic [15:0] idle_gap_o,
  output logic drive_proto_o,
  output logic [1:0] parity_o,
  output logic [15:0] wd_time_o
);

  localparam logic [17:0] PRE_LAST = 18'(MS_CYCLES - 1);

  fcw_main_t q;
  fcw_main_t d;
  logic rise_on;
  logic rise_ack;
  logic w_on;
  logic w_nocoast;
  logic w_nofast;
  logic w_op;
  logic ms_tick;
  logic wd_expire;
  logic fault_set;

  function automatic logic [15:0] sat_inc(input logic [15:0] v);
    sat_inc = (v == 16'hFFFF) ? v : v + 16'h0001;
  endfunction : sat_inc

  fcw_cmd_edge u_edge (
    .sys_clk_i(sys_clk_i),
    .rst_b_i(rst_b_i),
    .word_i(q.word),
    .rise_on_o(rise_on),
    .rise_ack_o(rise_ack)
  );

  assign w_on = q.word[`FCW_BIT_ON];
  assign w_nocoast = q.word[`FCW_BIT_NO_COAST];
  assign w_nofast = q.word[`FCW_BIT_NO_FAST];
  assign w_op = q.word[`FCW_BIT_OP_EN];
  assign ms_tick = (q.pre == PRE_LAST);
  // Trip once per loss, only under bus control
  assign wd_expire = (q.wd_time != 16'h0000) && q.word[`FCW_BIT_BUS_CTRL] // see RULE_06
                     && (q.wd_ms >= q.wd_time) && !q.wd_trip; // see RULE_22
  assign fault_set = drive_fault_i | wd_expire;

  always_comb
  begin
    d = q;
    // Command word; bus control low leaves the other commands untouched
    if (cmd_wr_i)
    begin
      if (cmd_word_i[`FCW_BIT_BUS_CTRL])
      begin
        d.word = cmd_word_i & `FCW_USED_MASK; // see RULE_16 see RULE_21
      end
      else
      begin
        d.word[`FCW_BIT_BUS_CTRL] = 1'b0; // see RULE_16
      end
    end
    // Settings
    if (par_wr_i)
    begin
      case (par_idx_i)
        `FCW_PAR_PROC_TIME: d.proc_time = par_data_i; // see RULE_01
        `FCW_PAR_CHAR_DELAY: d.char_delay = par_data_i; // see RULE_02
        `FCW_PAR_IDLE_GAP: d.idle_gap = par_data_i; // see RULE_02
        `FCW_PAR_PROTOCOL: d.protocol = par_data_i; // see RULE_04
        `FCW_PAR_PARITY:
        begin
          if (par_data_i[1:0] <= `FCW_PARITY_MAX && par_data_i[15:2] == 14'h0000)
          begin
            d.parity = par_data_i[1:0]; // see RULE_05
          end
        end
        `FCW_PAR_WD_TIME: d.wd_time = par_data_i; // see RULE_06
        default: d.parity = q.parity;
      endcase
    end
    // Error statistics, saturating
    for (int i = 0; i < 8; i++)
    begin
      if (err_evt_i[i])
      begin
        d.cnt[i] = sat_inc(q.cnt[i]); // see RULE_03
      end
    end
    d.cnt_rd = q.cnt[cnt_idx_i]; // see RULE_03
    // Watchdog: restart on each good telegram or while not monitoring
    d.pre = ms_tick ? 18'h00000 : q.pre + 18'h00001;
    if (err_evt_i[0] || q.wd_time == 16'h0000 || !q.word[`FCW_BIT_BUS_CTRL])
    begin
      d.wd_ms = 16'h0000; // see RULE_06
      d.wd_trip = 1'b0;
    end
    else
    begin
      if (ms_tick)
      begin
        d.wd_ms = sat_inc(q.wd_ms);
      end
      if (wd_expire)
      begin
        d.wd_trip = 1'b1; // see RULE_22
      end
    end
    // Fault flag; a new fault beats a simultaneous acknowledge
    if (fault_set)
    begin
      d.fault = 1'b1; // see RULE_19 see RULE_22
    end
    else if (rise_ack)
    begin
      d.fault = 1'b0; // see RULE_15 see RULE_19
    end
    // Drive sequencing
    if (fault_set || q.fault)
    begin
      d.st = FCW_ST_INHIBIT; // see RULE_15
    end
    else
    begin
      case (q.st)
        FCW_ST_INHIBIT:
        begin
          if (!w_on && w_nocoast && w_nofast)
          begin
            d.st = FCW_ST_RDY_START; // see RULE_20
          end
        end
        FCW_ST_RDY_START:
        begin
          if (!w_nocoast || !w_nofast)
          begin
            d.st = FCW_ST_INHIBIT; // see RULE_09 see RULE_10
          end
          else if (rise_on)
          begin
            d.st = FCW_ST_READY; // see RULE_08
          end
        end
        FCW_ST_READY, FCW_ST_OP_EN:
        begin
          if (!w_nocoast)
          begin
            d.st = FCW_ST_INHIBIT; // see RULE_09
          end
          else if (!w_nofast)
          begin
            d.st = FCW_ST_FAST_STOP; // see RULE_10
          end
          else if (!w_on)
          begin
            d.st = FCW_ST_RAMP_DN; // see RULE_07
          end
          else if (w_op)
          begin
            d.st = FCW_ST_OP_EN; // see RULE_08
          end
          else
          begin
            d.st = FCW_ST_READY; // see RULE_11
          end
        end
        FCW_ST_RAMP_DN:
        begin
          if (!w_nocoast)
          begin
            d.st = FCW_ST_INHIBIT; // see RULE_09
          end
          else if (!w_nofast)
          begin
            d.st = FCW_ST_FAST_STOP; // see RULE_10
          end
          else if (rise_on)
          begin
            d.st = FCW_ST_READY; // see RULE_08
          end
          else if (standstill_i)
          begin
            d.st = FCW_ST_RDY_START; // see RULE_07
          end
        end
        FCW_ST_FAST_STOP:
        begin
          if (!w_nocoast || standstill_i)
          begin
            d.st = FCW_ST_INHIBIT; // see RULE_10
          end
        end
        default: d.st = FCW_ST_INHIBIT;
      endcase
    end
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (!rst_b_i)
    begin
      q <= '0;
      q.st <= FCW_ST_INHIBIT;
      q.proc_time <= `FCW_RST_PROC_TIME; // see RULE_01
      q.char_delay <= `FCW_RST_CHAR_DELAY; // see RULE_02
      q.idle_gap <= `FCW_RST_IDLE_GAP; // see RULE_02
      q.protocol <= `FCW_RST_PROTOCOL;
      q.parity <= `FCW_RST_PARITY; // see RULE_05
      q.wd_time <= `FCW_RST_WD_TIME; // see RULE_06
    end
    else
    begin
      q <= d;
    end
  end

  // Pulses stay on while braking, off at once on coast or bit 3 low
  assign pulse_en_o = (q.st == FCW_ST_OP_EN || q.st == FCW_ST_RAMP_DN || q.st == FCW_ST_FAST_STOP)
                      && w_op && w_nocoast && !q.fault; // see RULE_11 see RULE_09
  assign ramp_stop_o = (q.st == FCW_ST_RAMP_DN); // see RULE_07
  assign coast_stop_o = !w_nocoast; // see RULE_09
  assign fast_stop_o = (q.st == FCW_ST_FAST_STOP); // see RULE_10
  assign rfg_zero_o = !q.word[`FCW_BIT_RFG_EN]; // see RULE_12
  assign rfg_hold_o = !q.word[`FCW_BIT_RFG_RUN]; // see RULE_13
  assign setpoint_en_o = q.word[`FCW_BIT_SP_EN]; // see RULE_14
  assign dir_rev_o = q.word[`FCW_BIT_DIR_REV]; // see RULE_17
  assign mop_up_o = q.word[`FCW_BIT_MOP_UP]; // see RULE_18
  assign mop_down_o = q.word[`FCW_BIT_MOP_DN]; // see RULE_18
  assign bus_ctrl_o = q.word[`FCW_BIT_BUS_CTRL]; // see RULE_16
  assign fault_o = q.fault;
  assign inhibit_o = (q.st == FCW_ST_INHIBIT);
  assign ready_o = (q.st == FCW_ST_READY || q.st == FCW_ST_OP_EN);
  assign op_en_o = (q.st == FCW_ST_OP_EN);
  assign proc_time_o = q.proc_time;
  assign char_delay_o = q.char_delay;
  assign idle_gap_o = q.idle_gap;
  assign drive_proto_o = (q.protocol == `FCW_PROTO_DRIVE); // see RULE_04
  assign parity_o = q.parity;
  assign wd_time_o = q.wd_time;
  assign cnt_data_o = q.cnt_rd;

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_b_i);

  sequence s_on_rise;
    !w_on ##1 w_on;
  endsequence

  sequence s_fault_ack;
    q.fault && rise_ack && !fault_set;
  endsequence

  // Nothing that would stop the switch-on sequence
  sequence s_run_ok;
    w_nocoast && w_nofast && !fault_set && !q.fault;
  endsequence

  a_fault_ack_clear: assert property (s_fault_ack |=> !q.fault) // see RULE_19
    else $error("fault not cleared by acknowledge");
  a_fault_held: assert property (q.fault && !rise_ack |=> q.fault) // see RULE_19
    else $error("fault dropped without acknowledge");
  a_fault_inhibit: assert property (q.fault |=> inhibit_o) // see RULE_15
    else $error("fault did not force inhibit");
  a_coast_pulses: assert property (!w_nocoast |-> !pulse_en_o) // see RULE_09
    else $error("pulses on during coast stop");
  a_op_pulses: assert property (!w_op |-> !pulse_en_o) // see RULE_11
    else $error("pulses on with operation inhibited");
  a_on_ready: assert property (q.st == FCW_ST_RDY_START ##0 s_run_ok ##0 s_on_rise ##0 s_run_ok [*2] // see RULE_08
                               |=> ready_o)
    else $error("switch-on edge did not reach ready");
  a_inhibit_hold: assert property (inhibit_o && w_on && !q.fault |=> inhibit_o) // see RULE_20
    else $error("left inhibit with switch-on still high");
  a_wd_fault: assert property (wd_expire |=> q.fault) // see RULE_22
    else $error("watchdog expiry did not raise fault");
  a_wd_off: assert property (q.wd_time == 16'h0000 |-> !wd_expire) // see RULE_06
    else $error("watchdog active while disabled");
  a_cnt_step: assert property (err_evt_i[2] && q.cnt[2] != 16'hFFFF
                               |=> q.cnt[2] == $past(q.cnt[2]) + 16'h0001) // see RULE_03
    else $error("framing error counter did not step");
  a_ramp_stop: assert property ((q.st == FCW_ST_READY || q.st == FCW_ST_OP_EN) && !w_on && w_nocoast
                                && w_nofast && !fault_set && !q.fault |=> ramp_stop_o) // see RULE_07
    else $error("switch-on low did not start ramp down");

endmodule : fcw_decoder
`default_nettype wire

// >>> inc/fcw_regs.svh
// Purpose: Constants for the drive command word decoder
// Assumes: 200 MHz system clock, times held in whole milliseconds
// Notes: Guarded; definitions only
// What this block does
// RULE_01 - Keep telegram processing time limit, 1000 ms after reset.
// RULE_02 - Keep character delay and inter-telegram gap, both 0 ms after reset.
// RULE_03 - Eight readable error counters: ok, rejected, framing, overrun, parity, start, checksum, length.
// RULE_04 - Protocol setting 1 selects the drive serial protocol.
// RULE_05 - Parity setting: 0 none, 1 odd, 2 even; even after reset.
// RULE_06 - Telegram loss watchdog, 100 ms after reset; 0 disables it.
// RULE_07 - Bit 0 low: ramp down with normal decel, drive off at standstill.
// RULE_08 - Bit 0 rising: go ready; with bit 3 high energize motor.
// RULE_09 - Bit 1 low: cut drive at once and coast; high allows switch-on.
// RULE_10 - Bit 2 low: fast stop to standstill; high allows switch-on.
// RULE_11 - Bit 3 low cancels pulses at once; high lets pulses run.
// RULE_12 - Bit 4 low forces ramp generator output to zero.
// RULE_13 - Bit 5 low freezes ramp generator output; high tracks setpoint.
// RULE_14 - Bit 6 low decelerates normally; high accelerates to setpoint.
// RULE_15 - Bit 7 rising acknowledges faults; switch-on still high gives inhibit state.
// RULE_16 - Bit 10 low: ignore bus process data; high: accept it.
// RULE_17 - Bit 11 high inverts the speed setpoint sign.
// RULE_18 - Bit 13 raises, bit 14 lowers the motorized setpoint.
// RULE_19 - Fault flag stays set until acknowledged through bit 7.
// RULE_20 - In inhibit, switch-on needs bit 0 low then high again.
// RULE_21 - Reserved bits 8, 9, 12, 15 are ignored.
// RULE_22 - Watchdog timeout under bus control raises a fault.
`ifndef FCW_REGS_SVH
`define FCW_REGS_SVH

`define FCW_CLK_PERIOD_NS 5
`define FCW_MS_NS 1000000

`define FCW_PAR_PROC_TIME 4'h0
`define FCW_PAR_CHAR_DELAY 4'h1
`define FCW_PAR_IDLE_GAP 4'h2
`define FCW_PAR_PROTOCOL 4'h3
`define FCW_PAR_PARITY 4'h4
`define FCW_PAR_WD_TIME 4'h5

`define FCW_RST_PROC_TIME 16'h03E8
`define FCW_RST_CHAR_DELAY 16'h0000
`define FCW_RST_IDLE_GAP 16'h0000
`define FCW_RST_PROTOCOL 16'h0001
`define FCW_RST_PARITY 2'h2
`define FCW_RST_WD_TIME 16'h0064

`define FCW_PROTO_DRIVE 16'h0001
`define FCW_PARITY_MAX 2'h2

`define FCW_BIT_ON 0
`define FCW_BIT_NO_COAST 1
`define FCW_BIT_NO_FAST 2
`define FCW_BIT_OP_EN 3
`define FCW_BIT_RFG_EN 4
`define FCW_BIT_RFG_RUN 5
`define FCW_BIT_SP_EN 6
`define FCW_BIT_ACK 7
`define FCW_BIT_BUS_CTRL 10
`define FCW_BIT_DIR_REV 11
`define FCW_BIT_MOP_UP 13
`define FCW_BIT_MOP_DN 14
`define FCW_USED_MASK 16'h6CFF

`endif

// >>> inc/fcw_pkg.sv
// Purpose: Types for the drive command word decoder
// Assumes: Nothing beyond the constants header
// Notes: State encoding left to the tool
`default_nettype none
package fcw_pkg;

  typedef enum logic [2:0] {
    FCW_ST_INHIBIT,
    FCW_ST_RDY_START,
    FCW_ST_READY,
    FCW_ST_OP_EN,
    FCW_ST_RAMP_DN,
    FCW_ST_FAST_STOP
  } fcw_state_t;

  typedef struct packed {
    logic [15:0] word;
    fcw_state_t st;
    logic fault;
    logic wd_trip;
    logic [17:0] pre;
    logic [15:0] wd_ms;
    logic [15:0] proc_time;
    logic [15:0] char_delay;
    logic [15:0] idle_gap;
    logic [15:0] protocol;
    logic [1:0] parity;
    logic [15:0] wd_time;
    logic [7:0][15:0] cnt;
    logic [15:0] cnt_rd;
  } fcw_main_t;

  typedef struct packed {
    logic [15:0] prev;
    logic rise_on;
    logic rise_ack;
  } fcw_edge_t;

endpackage : fcw_pkg
`default_nettype wire

// >>> logic/fcw_cmd_edge.sv
// Purpose: Rising edge detect on switch-on and acknowledge bits
// Assumes: Word is the registered effective command word
// Notes: Pulses last one cycle, one cycle after the word changes
`include "fcw_regs.svh"
`default_nettype none
module fcw_cmd_edge
  import fcw_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic rst_b_i,
  input wire logic [15:0] word_i,
  output logic rise_on_o,
  output logic rise_ack_o
);

  fcw_edge_t q;
  fcw_edge_t d;

  always_comb
  begin
    d = q;
    d.prev = word_i;
    d.rise_on = word_i[`FCW_BIT_ON] & ~q.prev[`FCW_BIT_ON]; // see RULE_08
    d.rise_ack = word_i[`FCW_BIT_ACK] & ~q.prev[`FCW_BIT_ACK]; // see RULE_15
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (!rst_b_i)
    begin
      q <= '0;
    end
    else
    begin
      q <= d;
    end
  end

  assign rise_on_o = q.rise_on;
  assign rise_ack_o = q.rise_ack;

endmodule : fcw_cmd_edge
`default_nettype wire

// >>> sim/fcw_plc_model.sv
// Purpose: Bus master model that writes drive command words
// Assumes: Writes launch on the falling clock edge
// Notes: Word lines show inverted junk between writes
`include "fcw_regs.svh"
`default_nettype none
module fcw_plc_model (
  input wire logic sys_clk_i,
  output logic cmd_wr_o,
  output logic [15:0] cmd_word_o
);
  timeunit 1ns;
  timeprecision 1ps;

  initial
  begin
    cmd_wr_o = 1'b0;
    cmd_word_o = 16'h0000;
  end

  // Reserved bits zero unless raw asked; at least one idle cycle between writes
  task automatic send(input logic [15:0] w, input logic raw);
    @(negedge sys_clk_i);
    cmd_wr_o = 1'b1;
    cmd_word_o = raw ? w : (w & `FCW_USED_MASK);
    @(negedge sys_clk_i);
    cmd_wr_o = 1'b0;
    cmd_word_o = ~cmd_word_o;
  endtask : send
endmodule : fcw_plc_model
`default_nettype wire

// >>> sim/fcw_decoder_tb.sv
// Purpose: Self-checking bench for the command word decoder
// Assumes: Ten-cycle millisecond, inputs driven on the falling edge
// Notes: Random words and events from a fixed xorshift seed
`default_nettype none
module fcw_decoder_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk = 1'b0;
  logic rst_b = 1'b0;
  logic cmd_wr, par_wr, drive_fault = 1'b0, standstill = 1'b0;
  logic [15:0] cmd_word, par_data = 16'h0000, cnt_data, proc_time, char_delay, idle_gap, wd_time;
  logic [3:0] par_idx = 4'h0;
  logic [7:0] err_evt = 8'h00;
  logic [2:0] cnt_idx = 3'h0;
  logic [1:0] parity;
  logic pulse_en, ramp_stop, coast_stop, fast_stop, rfg_zero, rfg_hold, sp_en, dir_rev;
  logic mop_up, mop_dn, bus_ctrl, fault, inhibit, ready, op_en, drive_proto;
  int n_fail = 0;
  int comparisons = 0;
  logic [31:0] seed = 32'd38652;
  logic [15:0] cnt_m [8];
  logic [15:0] held, w;
  logic [1:0] par_m;
  localparam logic [15:0] SW [14] = '{16'h0406, 16'h0407, 16'h040F, 16'h040E, 16'hFFFF, 16'h040F, 16'h040B,
    16'hFFFF, 16'h040E, 16'h040F, 16'hEEEE, 16'h048F, 16'h040E, 16'h040F};
  localparam logic [6:0] SE [14] = '{7'h00, 7'h20, 7'h38, 7'h0C, 7'h00, 7'h38, 7'h0A,
    7'h40, 7'h00, 7'h38, 7'h41, 7'h40, 7'h00, 7'h38};

  initial par_wr = 1'b0;
  always #2.5 sys_clk = ~sys_clk;

  fcw_plc_model plc (.sys_clk_i(sys_clk), .cmd_wr_o(cmd_wr), .cmd_word_o(cmd_word));

  fcw_decoder #(.MS_CYCLES(10)) uut (.sys_clk_i(sys_clk), .rst_b_i(rst_b), .cmd_wr_i(cmd_wr),
    .cmd_word_i(cmd_word), .par_wr_i(par_wr), .par_idx_i(par_idx), .par_data_i(par_data),
    .err_evt_i(err_evt), .cnt_idx_i(cnt_idx), .drive_fault_i(drive_fault), .standstill_i(standstill),
    .cnt_data_o(cnt_data), .pulse_en_o(pulse_en), .ramp_stop_o(ramp_stop), .coast_stop_o(coast_stop),
    .fast_stop_o(fast_stop), .rfg_zero_o(rfg_zero), .rfg_hold_o(rfg_hold), .setpoint_en_o(sp_en),
    .dir_rev_o(dir_rev), .mop_up_o(mop_up), .mop_down_o(mop_dn), .bus_ctrl_o(bus_ctrl), .fault_o(fault),
    .inhibit_o(inhibit), .ready_o(ready), .op_en_o(op_en), .proc_time_o(proc_time),
    .char_delay_o(char_delay), .idle_gap_o(idle_gap), .drive_proto_o(drive_proto), .parity_o(parity),
    .wd_time_o(wd_time));

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd

  function automatic logic [15:0] dec(input logic [15:0] v);
    return {8'h00, ~v[1], ~v[4], ~v[5], v[6], v[11], v[13], v[14], v[10]};
  endfunction : dec

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic tally_and_finish();
    $display("Counts: %0d comparisons, %0d mismatches", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : tally_and_finish

  task automatic cyc(input int n);
    repeat (n) @(negedge sys_clk);
  endtask : cyc

  task automatic do_reset();
    rst_b = 1'b0;
    cyc(4);
    rst_b = 1'b1;
    for (int i = 0; i < 8; i++)
      cnt_m[i] = 16'h0000;
    held = 16'h0000;
    par_m = 2'h2;
  endtask : do_reset

  task automatic set_par(input logic [3:0] idx, input logic [15:0] v);
    @(negedge sys_clk);
    par_wr = 1'b1;
    par_idx = idx;
    par_data = v;
    @(negedge sys_clk);
    par_wr = 1'b0;
    cyc(1);
  endtask : set_par

  initial
  begin
    do_reset();
    cyc(1);
    check("proc_time", proc_time, 16'h03E8);
    check("char_delay", char_delay, 16'h0000);
    check("idle_gap", idle_gap, 16'h0000);
    check("proto_parity", {13'h0000, drive_proto, parity}, 16'h0006);
    check("wd_time", wd_time, 16'h0064);
    check("idle_cmds", {8'h00, coast_stop, rfg_zero, rfg_hold, sp_en, dir_rev, mop_up, mop_dn, bus_ctrl},
      dec(16'h0000));
    check("inhibit", {15'h0000, inhibit}, 16'h0001);
    $display("done: reset values");
    for (int i = 0; i < 4; i++)
    begin
      w = 16'(rnd());
      set_par((i == 3) ? 4'h5 : 4'(i), w);
      check("setting", (i == 0) ? proc_time : (i == 1) ? char_delay : (i == 2) ? idle_gap : wd_time, w);
    end
    for (int p = 3; p >= 0; p--)
    begin
      set_par(4'h4, 16'(p));
      par_m = (p < 3) ? 2'(p) : par_m;
      check("parity", {14'h0000, parity}, {14'h0000, par_m});
    end
    for (int p = 0; p < 2; p++)
    begin
      set_par(4'h3, 16'(p));
      check("protocol", {15'h0000, drive_proto}, 16'(p));
    end
    $display("done: settings");
    for (int k = 0; k < 40; k++)
    begin
      err_evt = 8'(rnd());
      for (int i = 0; i < 8; i++)
        cnt_m[i] = cnt_m[i] + 16'(err_evt[i]);
      @(negedge sys_clk);
    end
    err_evt = 8'h00;
    for (int i = 0; i < 8; i++)
    begin
      cnt_idx = 3'(i);
      cyc(2);
      check("counter", cnt_data, cnt_m[i]);
    end
    $display("done: error counters");
    do_reset();
    for (int k = 0; k < 40; k++)
    begin
      w = 16'(rnd());
      w[10] = (k % 4) != 3;
      held = w[10] ? (w & 16'h6CFF) : {held[15:11], 1'b0, held[9:0]};
      plc.send(w, k[0]);
      check("decode", {8'h00, coast_stop, rfg_zero, rfg_hold, sp_en, dir_rev, mop_up, mop_dn, bus_ctrl},
        dec(held));
    end
    $display("done: command decode");
    do_reset();
    for (int s = 0; s < 14; s++)
    begin
      if (SW[s] == 16'hFFFF)
        standstill = 1'b1;
      else if (SW[s] == 16'hEEEE)
        drive_fault = 1'b1;
      else
        plc.send(SW[s], 1'b0);
      cyc(1);
      drive_fault = 1'b0;
      cyc(4);
      standstill = 1'b0;
      check("state", {9'h000, inhibit, ready, op_en, pulse_en, ramp_stop, fast_stop, fault},
        {9'h000, SE[s]});
    end
    plc.send(16'h0407, 1'b0);
    check("pulse_off", {15'h0000, pulse_en}, 16'h0000);
    plc.send(16'h040F, 1'b0);
    cyc(4);
    plc.send(16'h040D, 1'b0);
    check("coast", {14'h0000, pulse_en, coast_stop}, 16'h0001);
    $display("done: state sequence");
    do_reset();
    set_par(4'h5, 16'h0003);
    plc.send(16'h0400, 1'b0);
    for (int t = 0; t < 100 && fault !== 1'b1; t++)
    begin
      cyc(1);
    end
    check("wd_fault", {15'h0000, fault}, 16'h0001);
    set_par(4'h5, 16'h0000);
    plc.send(16'h0480, 1'b0);
    cyc(100);
    check("wd_off", {15'h0000, fault}, 16'h0000);
    $display("done: watchdog");
    tally_and_finish();
  end
endmodule : fcw_decoder_tb
`default_nettype wire
